//--- src/ctz_params.svh
// Offsets, field positions and reset values of the clock trim control block.
// Assumes a byte-addressed register port with one 32-bit word per register.
`ifndef CTZ_PARAMS_SVH
`define CTZ_PARAMS_SVH

`define CTZ_OFS_CTL0        8'h00
`define CTZ_OFS_CTL1        8'h04
`define CTZ_OFS_STAT        8'h08
`define CTZ_OFS_CLR         8'h0c

`define CTZ_CTL0_RST        32'h0000_2000
`define CTZ_CTL1_RST        32'h2022_bb7f
`define CTZ_CTL1_WMASK      32'hb7ff_ffff
`define CTZ_TRIM_RST        6'h20
`define CTZ_TRIM_MAX        6'h3f

`define CTZ_TRIM_LSB        8
`define CTZ_TRIM_MSB        13
`define CTZ_SOFT_PULSE_BIT  7
`define CTZ_HW_TRIM_BIT     6
`define CTZ_CNT_ON_BIT      5
`define CTZ_EN_MSB          3

`define CTZ_GOOD_BIT        0
`define CTZ_WARN_BIT        1
`define CTZ_ERR_BIT         2
`define CTZ_EREF_BIT        3

`define CTZ_LIM_LSB         16
`define CTZ_LIM_MSB         23
`define CTZ_RELOAD_MSB      15
`define CTZ_MISS_SHIFT      7

`endif

//--- src/ctz_pkg.sv
// Types shared by the clock trim control block.
// Assumes nothing of its surroundings.
package ctz_pkg;

    typedef enum logic [1:0] {
        CTZ_CNT_IDLE = 2'b00,
        CTZ_CNT_DOWN = 2'b01,
        CTZ_CNT_UP   = 2'b10,
        CTZ_CNT_HALT = 2'b11
    } ctz_cnt_state_type;

    typedef logic [5:0] ctz_trim_type;

endpackage

//--- src/ctz_sync_pulse.sv
// Reference sync pulse merge: software request joined with the external pulse.
// Assumes ext_pulse is already a one-cycle pulse synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none

module ctz_sync_pulse (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic soft_req,
    input  wire logic ext_pulse,
    output logic      sync_pulse
);

    logic soft_q;

    // One register stage keeps the software pulse a single clean cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= soft_req;
        end
    end

    assign sync_pulse = soft_q | ext_pulse;

endmodule // ctz_sync_pulse

`default_nettype wire

//--- src/ctz_trim_counter.sv
// Trim counter: reloads on each sync pulse, counts down to zero, then up to
// the miss limit and halts. Assumes one clock, pulses one cycle long.
`timescale 1ns/1ns
`default_nettype none
`include "ctz_params.svh"

module ctz_trim_counter #(
    parameter int CNT_W = 16,
    parameter int LIM_W = 8
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    input  wire logic                     enable,
    input  wire logic                     sync_pulse,
    input  wire logic [CNT_W-1:0]         reload,
    input  wire logic [LIM_W-1:0]         limit,
    output ctz_pkg::ctz_cnt_state_type    state_q,
    output logic      [CNT_W-1:0]         count_q,
    output logic                          zero_evt,
    output logic                          miss_evt
);

    ctz_pkg::ctz_cnt_state_type state_d;
    logic [CNT_W-1:0]           count_d;
    logic [CNT_W-1:0]           miss_top;

    assign miss_top = CNT_W'({limit, `CTZ_MISS_SHIFT'h0});
    assign zero_evt = (state_q == ctz_pkg::CTZ_CNT_DOWN) && (count_q == '0);
    assign miss_evt = (state_q == ctz_pkg::CTZ_CNT_UP) && (count_q == miss_top);

    always_comb begin
        state_d = state_q;
        count_d = count_q;
        if (!enable) begin
            state_d = ctz_pkg::CTZ_CNT_IDLE;
        end else if (sync_pulse) begin
            state_d = ctz_pkg::CTZ_CNT_DOWN;
            count_d = reload;
        end else begin
            case (state_q)
                ctz_pkg::CTZ_CNT_DOWN: begin
                    if (count_q == '0) begin
                        state_d = ctz_pkg::CTZ_CNT_UP;
                        count_d = CNT_W'(1);
                    end else begin
                        count_d = count_q - CNT_W'(1);
                    end
                end
                ctz_pkg::CTZ_CNT_UP: begin
                    if (count_q == miss_top) begin
                        state_d = ctz_pkg::CTZ_CNT_HALT;
                    end else begin
                        count_d = count_q + CNT_W'(1);
                    end
                end
                ctz_pkg::CTZ_CNT_IDLE: state_d = ctz_pkg::CTZ_CNT_IDLE;
                ctz_pkg::CTZ_CNT_HALT: state_d = ctz_pkg::CTZ_CNT_HALT;
                default:               state_d = ctz_pkg::CTZ_CNT_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= ctz_pkg::CTZ_CNT_IDLE;
            count_q <= '0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end

endmodule // ctz_trim_counter

`default_nettype wire

//--- src/ctz_trim_ctrl.sv
// Clock trim control: first control register with trim code, modes and
// interrupt enables, plus locked second control register, status and clear.
// Assumes a synchronous one-cycle external reference pulse on ext_pulse.
`timescale 1ns/1ns
`default_nettype none
`include "ctz_params.svh"

// What this block does
// - Control register resets to 0x00002000, trim code at midpoint.
// - With hardware trim off, software writes and reads trim code freely.
// - With hardware trim on, trim code is read-only, changed by hardware.
// - Trim code 32 is the centre; each step moves about 57KHz.
// - Writing one to bit 7 delivers one reference sync pulse.
// - Bit 7 clears itself and always reads zero; writing zero does nothing.
// - Bit 6 enables hardware trim on each reference evaluation.
// - Bit 5 enables the trim counter; clear disables it.
// - While counter enabled, writes to second control register are ignored.
// - Bit 3 gates the expected-reference flag onto the interrupt.
// - Bit 2 gates the combined error flag onto the interrupt.
// - Bit 1 gates the trim warning flag onto the interrupt.
// - Bit 0 gates the trim good flag onto the interrupt.
// - Hardware trim steps by one within limit to three times limit.
// - Trim code saturates at 0 and 63, flagging a range error.
module ctz_trim_ctrl #(
    parameter int CNT_W = 16,
    parameter int LIM_W = 8
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic        ext_pulse,
    output logic      [31:0] rd_data,
    output logic             irq,
    output logic      [5:0]  osc_trim_code
);

    // ==========================================================
    // Register state
    ctz_pkg::ctz_trim_type trim_q;
    ctz_pkg::ctz_trim_type trim_d;
    logic                  hw_trim_mode_q;
    logic                  trim_counter_on_q;
    logic [3:0]            irq_en_q;
    logic [31:0]           ctl1_q;
    logic [3:0]            flags_q;
    logic [3:0]            flags_d;
    logic [2:0]            err_src_q;
    logic [2:0]            err_src_d;
    logic [CNT_W-1:0]      cap_q;
    logic                  dir_q;
    logic [31:0]           rd_data_q;
    logic                  irq_q;

    // ==========================================================
    // Address decode
    wire sel_ctl0 = (addr == `CTZ_OFS_CTL0);
    wire sel_ctl1 = (addr == `CTZ_OFS_CTL1);
    wire sel_stat = (addr == `CTZ_OFS_STAT);
    wire sel_clr  = (addr == `CTZ_OFS_CLR);
    wire wr_ctl0  = wr_en && sel_ctl0;
    wire wr_ctl1  = wr_en && sel_ctl1 && !trim_counter_on_q;
    wire wr_clr   = wr_en && sel_clr;
    wire soft_req = wr_ctl0 && wr_data[`CTZ_SOFT_PULSE_BIT];

    wire [5:0] wr_trim = wr_data[`CTZ_TRIM_MSB:`CTZ_TRIM_LSB];
    wire [3:0] clr_bits = wr_clr ? wr_data[3:0] : 4'h0;

    // ==========================================================
    // Sync pulse and counter
    logic                       sync_pulse;
    ctz_pkg::ctz_cnt_state_type cnt_state;
    logic [CNT_W-1:0]           cnt;
    logic                       zero_evt;
    logic                       miss_evt;

    ctz_sync_pulse u_pulse (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .soft_req   (soft_req),
        .ext_pulse  (ext_pulse),
        .sync_pulse (sync_pulse)
    );

    ctz_trim_counter #(
        .CNT_W (CNT_W),
        .LIM_W (LIM_W)
    ) u_counter (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .enable     (trim_counter_on_q),
        .sync_pulse (sync_pulse),
        .reload     (ctl1_q[`CTZ_RELOAD_MSB:0]),
        .limit      (ctl1_q[`CTZ_LIM_MSB:`CTZ_LIM_LSB]),
        .state_q    (cnt_state),
        .count_q    (cnt),
        .zero_evt   (zero_evt),
        .miss_evt   (miss_evt)
    );

    // ==========================================================
    // Frequency evaluation at each sync pulse while the counter runs
    wire [CNT_W-1:0] lim1 = CNT_W'(ctl1_q[`CTZ_LIM_MSB:`CTZ_LIM_LSB]);
    wire [CNT_W-1:0] lim3 = CNT_W'(lim1 + (lim1 << 1));
    wire [CNT_W-1:0] top  = CNT_W'({ctl1_q[`CTZ_LIM_MSB:`CTZ_LIM_LSB],
                                    `CTZ_MISS_SHIFT'h0});
    wire             down = (cnt_state == ctz_pkg::CTZ_CNT_DOWN);
    wire             eval = sync_pulse && (cnt_state != ctz_pkg::CTZ_CNT_IDLE);

    wire in_good = cnt < lim3;
    wire in_one  = (cnt >= lim1) && (cnt < lim3);
    wire in_two  = (cnt >= lim3) && (cnt < top);

    wire good_evt  = eval && in_good;
    wire warn_evt  = eval && in_two;
    wire ckerr_evt = eval && down && (cnt >= top);

    // Coarse step when far off keeps convergence short
    wire [1:0] step   = in_one ? 2'h1 : (in_two ? 2'h2 : 2'h0);
    wire       adjust = hw_trim_mode_q && eval && (step != 2'h0);

    wire [6:0] up_sum = {1'b0, trim_q} + {5'h0, step};
    wire       over   = up_sum[6];
    wire       under  = trim_q < {4'h0, step};
    wire [5:0] dn_res = trim_q - {4'h0, step};

    wire trim_err_evt = adjust && (down ? over : under);
    wire [5:0] adj_trim = down ? (over ? `CTZ_TRIM_MAX : up_sum[5:0])
                               : (under ? 6'h00 : dn_res);

    always_comb begin
        trim_d = trim_q;
        if (wr_ctl0 && !hw_trim_mode_q) begin
            trim_d = wr_trim;
        end else if (adjust) begin
            trim_d = adj_trim;
        end
    end

    // ==========================================================
    // Sticky status flags; a set in the clear cycle wins
    wire       err_evt = trim_err_evt || miss_evt || ckerr_evt;
    wire [3:0] set_bits = {zero_evt, err_evt, warn_evt, good_evt};
    wire [2:0] src_set  = {trim_err_evt, miss_evt, ckerr_evt};

    assign flags_d   = (flags_q & ~clr_bits) | set_bits;
    assign err_src_d = (err_src_q & ~{3{clr_bits[`CTZ_ERR_BIT]}}) | src_set;

    // ==========================================================
    // Control register 0
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            trim_q            <= `CTZ_TRIM_RST;
            hw_trim_mode_q    <= 1'b0;
            trim_counter_on_q <= 1'b0;
            irq_en_q          <= 4'h0;
        end else begin
            trim_q <= trim_d;
            if (wr_ctl0) begin
                hw_trim_mode_q    <= wr_data[`CTZ_HW_TRIM_BIT];
                trim_counter_on_q <= wr_data[`CTZ_CNT_ON_BIT];
                irq_en_q          <= wr_data[`CTZ_EN_MSB:0];
            end
        end
    end

    // Control register 1, frozen while counter runs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctl1_q <= `CTZ_CTL1_RST;
        end else if (wr_ctl1) begin
            ctl1_q <= wr_data & `CTZ_CTL1_WMASK;
        end
    end

    // Status, capture and interrupt
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flags_q   <= 4'h0;
            err_src_q <= 3'h0;
            cap_q     <= '0;
            dir_q     <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            flags_q   <= flags_d;
            err_src_q <= err_src_d;
            irq_q     <= |(flags_q & irq_en_q);
            if (eval) begin
                cap_q <= cnt;
                dir_q <= down;
            end
        end
    end

    // ==========================================================
    // Read path; the pulse bit and reserved bits always read zero
    wire [31:0] ctl0_rd = {18'h0, trim_q, 1'b0, hw_trim_mode_q,
                           trim_counter_on_q, 1'b0, irq_en_q};
    wire [31:0] stat_rd = {cap_q, dir_q, 4'h0, err_src_q, 4'h0, flags_q};
    wire [31:0] rd_mux  = sel_ctl0 ? ctl0_rd :
                          sel_ctl1 ? ctl1_q  :
                          sel_stat ? stat_rd : 32'h0;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_data_q <= 32'h0;
        end else begin
            rd_data_q <= rd_en ? rd_mux : 32'h0;
        end
    end

    assign rd_data       = rd_data_q;
    assign irq           = irq_q;
    assign osc_trim_code = trim_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_reset_value:
    assert property ($rose(rst_n) |-> trim_q == 6'h20 && !hw_trim_mode_q
                     && !trim_counter_on_q && irq_en_q == 4'h0)
        else $error("control register not at reset value");

    a_manual_write:
    assert property (wr_ctl0 && !hw_trim_mode_q
                     |=> trim_q == $past(wr_data[13:8]))
        else $error("manual trim write lost");

    a_auto_locks:
    assert property (wr_ctl0 && hw_trim_mode_q && !adjust
                     |=> trim_q == $past(trim_q))
        else $error("software changed trim in hardware mode");

    a_pulse_once:
    assert property (soft_req && !ext_pulse ##1 !soft_req && !ext_pulse ##1 !ext_pulse
                     |-> !sync_pulse && $past(sync_pulse))
        else $error("software pulse not a single cycle");

    a_pulse_reads_zero:
    assert property (rd_en && sel_ctl0 |=> rd_data[7] == 1'b0)
        else $error("pulse bit read as one");

    a_counter_off:
    assert property (!trim_counter_on_q |=> cnt_state == ctz_pkg::CTZ_CNT_IDLE)
        else $error("counter running while disabled");

    a_ctl1_locked:
    assert property (wr_en && sel_ctl1 && trim_counter_on_q
                     |=> ctl1_q == $past(ctl1_q))
        else $error("second control register changed while locked");

    a_irq_gate:
    assert property ((flags_q & irq_en_q) == 4'h0 |=> !irq)
        else $error("interrupt without enabled flag");

    a_irq_raise:
    assert property ((flags_q & irq_en_q) != 4'h0 |=> irq)
        else $error("enabled flag did not raise interrupt");

    a_step_one:
    assert property (adjust && in_one && down && trim_q != 6'h3f
                     |=> trim_q == $past(trim_q) + 6'h1)
        else $error("single trim step wrong");

    a_saturate:
    assert property (trim_err_evt && down
                     |=> trim_q == 6'h3f && err_src_q[2] && flags_q[2])
        else $error("trim overflow not saturated or flagged");

    a_underflow:
    assert property (trim_err_evt && !down
                     |=> trim_q == 6'h00 && err_src_q[2] && flags_q[2])
        else $error("trim underflow not saturated or flagged");

    a_step_two:
    assert property (adjust && in_two && !down && trim_q >= 6'h02
                     |=> trim_q == $past(trim_q) - 6'h02)
        else $error("double trim step down wrong");

    // Without hardware mode an evaluation only reports, never retunes
    a_manual_hold:
    assert property (eval && !hw_trim_mode_q && !wr_ctl0 |=> trim_q == $past(trim_q))
        else $error("trim changed by evaluation in manual mode");

    a_flag_sticky:
    assert property (set_bits != 4'h0 |=> (flags_q & $past(set_bits)) == $past(set_bits))
        else $error("status flag event lost");

    c_auto_adjust: cover property (adjust ##1 adjust);
    c_ref_miss:    cover property (miss_evt);
    c_irq_on:      cover property ($rose(irq));
    c_range_error: cover property (trim_err_evt);

endmodule // ctz_trim_ctrl

`default_nettype wire

//--- tb/ctz_trim_ctrl_tb.sv
// Self-checking bench for the clock trim control block, driven over its register port.
// Assumes the sources under src/ and one 100 MHz clock with a synchronous reset.
`timescale 1ns/1ns
`default_nettype none
`include "ctz_params.svh"

module ctz_trim_ctrl_tb;
    logic        ref_clk;
    logic        rst_n;
    logic [7:0]  addr;
    logic [31:0] wr_data;
    logic        wr_en;
    logic        rd_en;
    logic        ext_pulse;
    logic [31:0] rd_data;
    logic        irq;
    logic [5:0]  osc_trim_code;
    logic [31:0] v;
    int          n_errors;
    int          comparisons;

    ctz_trim_ctrl DUT (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .addr          (addr),
        .wr_data       (wr_data),
        .wr_en         (wr_en),
        .rd_en         (rd_en),
        .ext_pulse     (ext_pulse),
        .rd_data       (rd_data),
        .irq           (irq),
        .osc_trim_code (osc_trim_code)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ============================================================
    // Access tasks
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Word writes only, one strobe cycle, never beside a read
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(negedge ref_clk);
        d = rd_data;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask

    task automatic pulse();
        @(posedge ref_clk);
        ext_pulse <= 1'b1;
        @(posedge ref_clk);
        ext_pulse <= 1'b0;
    endtask

    // ============================================================
    // At most one evaluation (none when p2 is low): limit 4, so bands at 4, 12 and 512 counts.
    // Margins of a few counts keep the band choice clear of edge timing.
    task automatic run(input logic hw, input logic [5:0] st, input logic [15:0] rl,
                       input int gap, input logic p2, input logic [15:0] es,
                       input logic [5:0] et, input logic [3:0] en, input string nm);
        logic [31:0] base;
        base = {18'h0, et, 1'b0, hw, 6'h20};
        wr(`CTZ_OFS_CTL0, {18'h0, st, 8'h00});
        wr(`CTZ_OFS_CTL1, {8'h20, 8'h04, rl});
        wr(`CTZ_OFS_CTL0, {18'h0, st, 1'b0, hw, 6'h20});
        wr(`CTZ_OFS_CTL0, {18'h0, st, 1'b1, hw, 6'h20});
        tick(1);
        wr(`CTZ_OFS_CLR, 32'h0000_000f);
        tick(gap - 4);
        if (p2) begin
            pulse();
        end
        tick(3);
        rd(`CTZ_OFS_STAT, v);
        chk({17'h0, v[14:0]}, {17'h0, es[14:0]});
        rchk(`CTZ_OFS_CTL0, base);
        chk({26'h0, osc_trim_code}, {26'h0, et});
        chk({31'h0, irq}, 32'h0);
        // In hardware mode a different trim is offered and must be dropped
        wr(`CTZ_OFS_CTL0, (base ^ {18'h0, {6{hw}} & 6'h15, 8'h0}) | {28'h0, en});
        tick(2);
        rchk(`CTZ_OFS_CTL0, base | {28'h0, en});
        chk({31'h0, irq}, 32'h1);
        wr(`CTZ_OFS_CLR, 32'h0000_000f);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        wr(`CTZ_OFS_CTL0, {18'h0, et, 8'h00});
        $display("Test %s done", nm);
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        rst_n = 1'b0;
        addr = 8'h00;
        wr_data = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        ext_pulse = 1'b0;
        n_errors = 0;
        comparisons = 0;
        tick(6);
        rst_n <= 1'b1;
        rchk(`CTZ_OFS_CTL0, 32'h0000_2000);
        chk({26'h0, osc_trim_code}, 32'h0000_0020);
        chk({31'h0, irq}, 32'h0);
        rchk(`CTZ_OFS_CTL1, 32'h2022_bb7f);
        rchk(`CTZ_OFS_STAT, 32'h0);
        rchk(`CTZ_OFS_CLR, 32'h0);
        rchk(8'h10, 32'h0);
        $display("Test reset done");
        wr(`CTZ_OFS_CTL0, 32'h0000_2020);
        wr(`CTZ_OFS_CTL1, 32'h0004_1234);
        rchk(`CTZ_OFS_CTL1, 32'h2022_bb7f);
        wr(`CTZ_OFS_CTL0, 32'h0000_2000);
        wr(`CTZ_OFS_CTL1, 32'h2004_1234);
        rchk(`CTZ_OFS_CTL1, 32'h2004_1234);
        wr(`CTZ_OFS_STAT, 32'hffff_ffff);
        wr(8'h10, 32'hffff_ffff);
        rchk(`CTZ_OFS_STAT, 32'h0);
        rchk(`CTZ_OFS_CTL0, 32'h0000_2000);
        $display("Test lock done");
        run(1'b0, 6'h20, 16'd100, 93, 1'b1, 16'h0001, 6'h20, 4'h1, "manual");
        run(1'b1, 6'h20, 16'd100, 93, 1'b1, 16'h0001, 6'h21, 4'h1, "step1");
        run(1'b1, 6'h21, 16'd100, 50, 1'b1, 16'h0002, 6'h23, 4'h2, "warn");
        run(1'b1, 6'h23, 16'd1000, 20, 1'b1, 16'h0104, 6'h23, 4'h4, "slow");
        run(1'b1, 6'h23, 16'd10, 552, 1'b0, 16'h020c, 6'h23, 4'h8, "miss");
        run(1'b1, 6'h23, 16'd10, 42, 1'b1, 16'h000a, 6'h21, 4'h2, "fast");
        run(1'b1, 6'h3f, 16'd100, 50, 1'b1, 16'h0406, 6'h3f, 4'h4, "ovf");
        run(1'b1, 6'h01, 16'd10, 42, 1'b1, 16'h040e, 6'h00, 4'h4, "udf");
        close_out();
    end

    // Whole run needs about 1200 cycles; allow far more before cutting off
    initial begin
        tick(50000);
        n_errors++;
        $display("Error t=%0t watchdog expired", $time);
        close_out();
    end
endmodule // ctz_trim_ctrl_tb

`default_nettype wire
